// ===== core/psc_byte_reg.sv
// One byte register with a reset value and a mask of writable bits.
// Assumes the bank raises wrStrobe for one cycle per decoded write.
module psc_byte_reg #(
  parameter logic [7:0] RESET_VAL  = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  psc_reg_if.store port
);
  import psc_pkg::*;

  logic [7:0] storeReg;
  logic [7:0] storeNext;

  ////////////////////////////////////////////////////////////////////////////
  // RULE1: unused bits dropped
  assign storeNext = port.wrData & WRITE_MASK;

  // RULE14: write takes effect next cycle
  always_ff @(posedge port.clk) begin
    if (port.rst) begin
      storeReg <= RESET_VAL;
    end else if (port.clkEn && port.wrStrobe) begin
      storeReg <= storeNext;
    end
  end

  assign port.value = storeReg;

endmodule : psc_byte_reg

// ===== core/psc_pkg.sv
// Package for the power stage configuration register bank.
// Assumes byte-wide register access with 8-bit offsets.
package psc_pkg;

  localparam int          NUM_REGS  = 3;
  localparam int          DATA_W    = 8;
  localparam int          ADDR_W    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_SECOND_OVERVOLTAGE_THRESHOLD = 8'hD5;
  localparam logic [7:0] OFS_POWER_STAGE_TIMING_CONFIG    = 8'hD6;
  localparam logic [7:0] OFS_DERATING_SLOPE_CONFIG        = 8'hD7;

  // Reset values
  localparam logic [7:0] RST_SECOND_OVERVOLTAGE_THRESHOLD = 8'h3F;
  localparam logic [7:0] RST_POWER_STAGE_TIMING_CONFIG    = 8'h15;
  localparam logic [7:0] RST_DERATING_SLOPE_CONFIG        = 8'h28;

  // Writable bits; the rest are unused_bits, reading zero
  localparam logic [7:0] MSK_SECOND_OVERVOLTAGE_THRESHOLD = 8'h3F;
  localparam logic [7:0] MSK_POWER_STAGE_TIMING_CONFIG    = 8'hFF;
  localparam logic [7:0] MSK_DERATING_SLOPE_CONFIG        = 8'h3F;

  // Index order of the bank
  localparam int IDX_OVP    = 0;
  localparam int IDX_TIMING = 1;
  localparam int IDX_SLOPE  = 2;

  localparam logic [NUM_REGS-1:0][7:0] REG_OFFSETS = {
    OFS_DERATING_SLOPE_CONFIG, OFS_POWER_STAGE_TIMING_CONFIG,
    OFS_SECOND_OVERVOLTAGE_THRESHOLD};
  localparam logic [NUM_REGS-1:0][7:0] REG_RESETS = {
    RST_DERATING_SLOPE_CONFIG, RST_POWER_STAGE_TIMING_CONFIG,
    RST_SECOND_OVERVOLTAGE_THRESHOLD};
  localparam logic [NUM_REGS-1:0][7:0] REG_MASKS = {
    MSK_DERATING_SLOPE_CONFIG, MSK_POWER_STAGE_TIMING_CONFIG,
    MSK_SECOND_OVERVOLTAGE_THRESHOLD};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int OVP_LEVEL_MSB     = 5;
  localparam int OVP_LEVEL_LSB     = 0;
  localparam int SYNC_MODE_MSB     = 7;
  localparam int SYNC_MODE_LSB     = 6;
  localparam int CONST_DT_BIT      = 5;
  localparam int DT_SCALE_BIT      = 4;
  localparam int MIN_DT_MSB        = 3;
  localparam int MIN_DT_LSB        = 2;
  localparam int MIN_TIME_MSB      = 1;
  localparam int MIN_TIME_LSB      = 0;
  localparam int DERATE_MSB        = 5;
  localparam int DERATE_LSB        = 4;
  localparam int SLOPE_MSB         = 3;
  localparam int SLOPE_LSB         = 0;

  // Sync pin functions
  typedef enum logic [1:0] {
    PSC_SYNC_IN_RISE,
    PSC_SYNC_IN_FALL,
    PSC_SYNC_OUT_RISE,
    PSC_SYNC_OUT_FALL
  } psc_sync_e;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold decode, in half volts
  localparam logic [5:0] OVP_FINE_LAST_CODE = 6'h18;
  localparam logic [6:0] OVP_FINE_BASE_HV   = 7'h08;
  localparam logic [6:0] OVP_COARSE_OFS_HV  = 7'h10;

  // Minimum dead time in ns per code
  localparam logic [5:0] DT_NS_CODE0 = 6'h0A;
  localparam logic [5:0] DT_NS_CODE1 = 6'h14;
  localparam logic [5:0] DT_NS_CODE2 = 6'h28;
  localparam logic [5:0] DT_NS_CODE3 = 6'h3C;

  // Minimum on/off time scale in quarters
  localparam logic [2:0] MIN_TIME_BASE_Q = 3'h3;

  // Inductor derating in percent per code
  localparam logic [5:0] DERATE_PCT_CODE0 = 6'h00;
  localparam logic [5:0] DERATE_PCT_CODE1 = 6'h14;
  localparam logic [5:0] DERATE_PCT_CODE2 = 6'h1E;
  localparam logic [5:0] DERATE_PCT_CODE3 = 6'h28;

  // Slope compensation ratio in eighths
  localparam logic [3:0] SLOPE_FINE_LAST_CODE = 4'h7;
  localparam logic [5:0] SLOPE_FINE_OFS_E     = 6'h01;
  localparam logic [5:0] SLOPE_COARSE_OFS_E   = 6'h14;

  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : psc_pkg

// ===== core/psc_power_stage_config_registers.sv
// Top of the power stage configuration register bank: three byte
// registers, a read port and static control outputs to the power stage.
// Assumes the serial control front end delivers decoded byte accesses
// synchronous to clk, one strobe per access.
//
// Functional notes
// RULE1: Bits 7 to 6 of the threshold and derating/slope registers ignore writes and read zero.
// RULE2: Offset 0xD5 resets to 0x3F and keeps the threshold code read/write in bits 5 to 0.
// RULE3: Codes 0x0 to 0x18 give 4.0 V to 16.0 V in 0.5 V steps.
// RULE4: Codes from 0x19 give 17 V upward in 1 V steps, up to 55 V at code 0x3F.
// RULE5: Bits 7 to 6 of the timing register pick sync input rise/fall or output rise/fall.
// RULE6: Bit 5 forces a constant dead time equal to the selected minimum.
// RULE7: Bit 4 enables scaling of the frequency-dependent dead time, reset one.
// RULE8: Bits 3 to 2 select minimum dead time 10, 20, 40 or 60 ns, reset 20 ns.
// RULE9: Bits 1 to 0 scale the minimum on/off time by 0.75, 1, 1.25 or 1.5.
// RULE10: Offset 0xD6 resets to 0x15 with every field read/write.
// RULE11: Bits 5 to 4 of 0xD7 select inductor derating off, 20, 30 or 40 percent.
// RULE12: Bits 3 to 0 select slope ratio 0.125 to 1 by eighths, then 1.5 to 5 by halves.
// RULE13: Offset 0xD7 resets to 0x28.
// RULE14: Stored fields drive static outputs, updated the cycle after a write; the decoded outputs update one cycle later.
module psc_power_stage_config_registers (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  input  wire logic [psc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [psc_pkg::DATA_W-1:0] regWrData,
  output logic [psc_pkg::DATA_W-1:0] regRdData,
  output logic                       regRdValid,
  output logic [5:0]                 secondOvervoltageLevel,
  output logic [6:0]                 ovpLevelHalfVolts,
  output psc_pkg::psc_sync_e         syncPinMode,
  output logic                       syncDrivesPin,
  output logic                       syncFallingEdge,
  output logic                       constDeadtimeEnable,
  output logic                       deadtimeScalingEnable,
  output logic [1:0]                 gateMinDeadtimeSelect,
  output logic [5:0]                 minDeadtimeNs,
  output logic [1:0]                 refreshMinTimeScale,
  output logic [2:0]                 minTimeScaleQuarters,
  output logic [1:0]                 inductorDeratingSelect,
  output logic [5:0]                 deratingPercent,
  output logic [3:0]                 slopeCompSelect,
  output logic [5:0]                 slopeRatioEighths
);
  import psc_pkg::*;

  psc_reg_if regIf [NUM_REGS] ();

  logic [NUM_REGS-1:0]         hitVec;
  logic [NUM_REGS-1:0][7:0]    valueVec;
  logic [7:0]                  rdMux;
  logic [7:0]                  rdDataReg;
  logic                        rdValidReg;

  logic [7:0]                  ovpByte;
  logic [7:0]                  timingByte;
  logic [7:0]                  slopeByte;

  logic [6:0]                  ovpHvReg;
  logic [6:0]                  ovpHvNext;
  logic                        syncDrivesReg;
  logic                        syncFallReg;
  logic [5:0]                  deadtimeNsReg;
  logic [5:0]                  deadtimeNsNext;
  logic [2:0]                  minTimeQReg;
  logic [5:0]                  deratePctReg;
  logic [5:0]                  deratePctNext;
  logic [5:0]                  slopeEReg;
  logic [5:0]                  slopeENext;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank, one store per offset
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_bank
    assign hitVec[i]         = (regAddr == REG_OFFSETS[i]);
    assign regIf[i].clk      = clk;
    assign regIf[i].rst      = sys_rst;
    assign regIf[i].clkEn    = clkEn;
    assign regIf[i].wrStrobe = regWrEn && hitVec[i];
    assign regIf[i].wrData   = regWrData;
    assign valueVec[i]       = regIf[i].value;

    // RULE2: reset values per offset
    // RULE10: timing register fully writable
    // RULE13: derating/slope reset value
    psc_byte_reg #(
      .RESET_VAL  (REG_RESETS[i]),
      .WRITE_MASK (REG_MASKS[i])
    ) u_store (
      .port (regIf[i])
    );
  end

  assign ovpByte    = valueVec[IDX_OVP];
  assign timingByte = valueVec[IDX_TIMING];
  assign slopeByte  = valueVec[IDX_SLOPE];

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    rdMux = RD_UNMAPPED;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (hitVec[k]) begin
        // RULE1: masked bits stored as zero
        rdMux = valueVec[k];
      end
    end
  end

  // Reads see the value before a same-cycle write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdDataReg <= RD_UNMAPPED;
    end else if (clkEn && regRdEn) begin
      rdDataReg <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValidReg <= 1'h0;
    end else if (clkEn) begin
      rdValidReg <= regRdEn;
    end
  end

  assign regRdData  = rdDataReg;
  assign regRdValid = rdValidReg;

  ////////////////////////////////////////////////////////////////////////////
  // Raw field outputs, straight from the stores
  // RULE14: static fields to the power stage
  assign secondOvervoltageLevel = ovpByte[OVP_LEVEL_MSB:OVP_LEVEL_LSB];
  assign syncPinMode            = psc_sync_e'(timingByte[SYNC_MODE_MSB:SYNC_MODE_LSB]);
  assign constDeadtimeEnable    = timingByte[CONST_DT_BIT];
  assign deadtimeScalingEnable  = timingByte[DT_SCALE_BIT];
  assign gateMinDeadtimeSelect  = timingByte[MIN_DT_MSB:MIN_DT_LSB];
  assign refreshMinTimeScale    = timingByte[MIN_TIME_MSB:MIN_TIME_LSB];
  assign inductorDeratingSelect = slopeByte[DERATE_MSB:DERATE_LSB];
  assign slopeCompSelect        = slopeByte[SLOPE_MSB:SLOPE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Decoded views, registered one cycle behind the fields
  always_comb begin
    // RULE3: fine half-volt range
    if (secondOvervoltageLevel <= OVP_FINE_LAST_CODE) begin
      ovpHvNext = {1'h0, secondOvervoltageLevel} + OVP_FINE_BASE_HV;
    end else begin
      // RULE4: coarse one-volt range
      ovpHvNext = {secondOvervoltageLevel, 1'h0} - OVP_COARSE_OFS_HV;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovpHvReg <= {RST_SECOND_OVERVOLTAGE_THRESHOLD[OVP_LEVEL_MSB:OVP_LEVEL_LSB], 1'h0} -
                  OVP_COARSE_OFS_HV;
    end else if (clkEn) begin
      ovpHvReg <= ovpHvNext;
    end
  end

  // RULE5: sync direction and edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncDrivesReg <= 1'h0;
      syncFallReg   <= 1'h0;
    end else if (clkEn) begin
      syncDrivesReg <= (syncPinMode == PSC_SYNC_OUT_RISE) ||
                       (syncPinMode == PSC_SYNC_OUT_FALL);
      syncFallReg   <= (syncPinMode == PSC_SYNC_IN_FALL) ||
                       (syncPinMode == PSC_SYNC_OUT_FALL);
    end
  end

  always_comb begin
    // RULE8: minimum dead time lookup
    unique case (gateMinDeadtimeSelect)
      2'h0: deadtimeNsNext = DT_NS_CODE0;
      2'h1: deadtimeNsNext = DT_NS_CODE1;
      2'h2: deadtimeNsNext = DT_NS_CODE2;
      2'h3: deadtimeNsNext = DT_NS_CODE3;
    endcase
  end

  // RULE6: constant mode uses this value as is
  // RULE7: scaling flag passed alongside, not folded in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deadtimeNsReg <= DT_NS_CODE1;
    end else if (clkEn) begin
      deadtimeNsReg <= deadtimeNsNext;
    end
  end

  // RULE9: scale in quarters, 3 to 6
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      minTimeQReg <= MIN_TIME_BASE_Q +
                     3'(RST_POWER_STAGE_TIMING_CONFIG[MIN_TIME_MSB:MIN_TIME_LSB]);
    end else if (clkEn) begin
      minTimeQReg <= MIN_TIME_BASE_Q + {1'h0, refreshMinTimeScale};
    end
  end

  always_comb begin
    // RULE11: derating percent lookup
    unique case (inductorDeratingSelect)
      2'h0: deratePctNext = DERATE_PCT_CODE0;
      2'h1: deratePctNext = DERATE_PCT_CODE1;
      2'h2: deratePctNext = DERATE_PCT_CODE2;
      2'h3: deratePctNext = DERATE_PCT_CODE3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deratePctReg <= DERATE_PCT_CODE2;
    end else if (clkEn) begin
      deratePctReg <= deratePctNext;
    end
  end

  always_comb begin
    // RULE12: eighths below code 8, halves above
    if (slopeCompSelect <= SLOPE_FINE_LAST_CODE) begin
      slopeENext = {2'h0, slopeCompSelect} + SLOPE_FINE_OFS_E;
    end else begin
      slopeENext = {slopeCompSelect, 2'h0} - SLOPE_COARSE_OFS_E;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slopeEReg <= {RST_DERATING_SLOPE_CONFIG[SLOPE_MSB:SLOPE_LSB], 2'h0} - SLOPE_COARSE_OFS_E;
    end else if (clkEn) begin
      slopeEReg <= slopeENext;
    end
  end

  assign ovpLevelHalfVolts    = ovpHvReg;
  assign syncDrivesPin        = syncDrivesReg;
  assign syncFallingEdge      = syncFallReg;
  assign minDeadtimeNs        = deadtimeNsReg;
  assign minTimeScaleQuarters = minTimeQReg;
  assign deratingPercent      = deratePctReg;
  assign slopeRatioEighths    = slopeEReg;

endmodule : psc_power_stage_config_registers

// ===== core/psc_reg_if.sv
// Interface between the bank top and each stored byte register.
// Assumes a single clock, synchronous reset and clock enable.
interface psc_reg_if;
  logic       clk;
  logic       rst;
  logic       clkEn;
  logic       wrStrobe;
  logic [7:0] wrData;
  logic [7:0] value;

  modport bank (
    output clk,
    output rst,
    output clkEn,
    output wrStrobe,
    output wrData,
    input  value
  );

  modport store (
    input  clk,
    input  rst,
    input  clkEn,
    input  wrStrobe,
    input  wrData,
    output value
  );
endinterface : psc_reg_if

// ===== test/psc_regs_chk.sv
// Checker for the power stage configuration register bank.
// Assumes one clock domain and the synchronous active-high reset.
module psc_regs_chk import psc_pkg::*; (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdValid,
  input wire logic [5:0]  secondOvervoltageLevel,
  input wire logic [6:0]  ovpLevelHalfVolts,
  input wire psc_sync_e   syncPinMode,
  input wire logic        syncDrivesPin,
  input wire logic        syncFallingEdge,
  input wire logic [3:0]  slopeCompSelect,
  input wire logic [5:0]  slopeRatioEighths
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wrOvp;
  logic rdLow;
  assign wrOvp = clkEn && regWrEn && regAddr == 8'hD5;
  assign rdLow = clkEn && regRdEn && (regAddr == 8'hD5 || regAddr == 8'hD7);
  ////////////////////////////////////////////////////////////////////////////
  ovp_store_a: assert property (wrOvp |=> secondOvervoltageLevel == $past(regWrData[5:0]))
    else $error("threshold write not stored");
  ovp_hold_a: assert property (!wrOvp |=> $stable(secondOvervoltageLevel))
    else $error("threshold changed without write");
  unused_zero_a: assert property (rdLow |=> regRdValid && regRdData[7:6] == 2'b00)
    else $error("unused bits not zero");
  ovp_read_a: assert property (rdLow && !regWrEn && regAddr == 8'hD5
    |=> regRdData == {2'b00, $past(secondOvervoltageLevel)}) else $error("threshold readback");
  ovp_fine_a: assert property (clkEn && secondOvervoltageLevel <= 6'h18 |=>
    ovpLevelHalfVolts == {1'b0, $past(secondOvervoltageLevel)} + 7'h08) else $error("fine decode");
  ovp_coarse_a: assert property (clkEn && secondOvervoltageLevel > 6'h18 |=>
    ovpLevelHalfVolts == {$past(secondOvervoltageLevel), 1'b0} - 7'h10) else $error("coarse decode");
  sync_flags_a: assert property (clkEn |=>
    {syncDrivesPin, syncFallingEdge} == $past(syncPinMode)) else $error("sync flags");
  slope_fine_a: assert property (clkEn && !slopeCompSelect[3] |=>
    slopeRatioEighths == {2'b00, $past(slopeCompSelect)} + 6'h01) else $error("slope fine");
  slope_coarse_a: assert property (clkEn && slopeCompSelect[3] |=>
    slopeRatioEighths == {$past(slopeCompSelect), 2'b00} - 6'h14) else $error("slope coarse");
  cover property (wrOvp);
  cover property (rdLow && regAddr == 8'hD7);
  cover property (clkEn && syncPinMode == PSC_SYNC_OUT_FALL);
endmodule : psc_regs_chk

bind psc_power_stage_config_registers psc_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .secondOvervoltageLevel(secondOvervoltageLevel), .ovpLevelHalfVolts(ovpLevelHalfVolts),
  .syncPinMode(syncPinMode), .syncDrivesPin(syncDrivesPin),
  .syncFallingEdge(syncFallingEdge), .slopeCompSelect(slopeCompSelect),
  .slopeRatioEighths(slopeRatioEighths));

// ===== test/tb_top.sv
// Testbench for the power stage configuration register bank.
// Assumes the byte strobe access port and a 250 MHz clock.
module tb_top import psc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic regRdValid, syncDrivesPin, syncFallingEdge, constDeadtimeEnable, deadtimeScalingEnable;
  logic [5:0] secondOvervoltageLevel, minDeadtimeNs, deratingPercent, slopeRatioEighths;
  logic [6:0] ovpLevelHalfVolts;
  logic [2:0] minTimeScaleQuarters;
  logic [1:0] gateMinDeadtimeSelect, refreshMinTimeScale, inductorDeratingSelect;
  logic [3:0] slopeCompSelect;
  psc_sync_e  syncPinMode;
  int error_cnt = 0;
  int cmp_count = 0;

  psc_power_stage_config_registers u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .secondOvervoltageLevel(secondOvervoltageLevel), .ovpLevelHalfVolts(ovpLevelHalfVolts),
    .syncPinMode(syncPinMode), .syncDrivesPin(syncDrivesPin),
    .syncFallingEdge(syncFallingEdge), .constDeadtimeEnable(constDeadtimeEnable),
    .deadtimeScalingEnable(deadtimeScalingEnable),
    .gateMinDeadtimeSelect(gateMinDeadtimeSelect), .minDeadtimeNs(minDeadtimeNs),
    .refreshMinTimeScale(refreshMinTimeScale), .minTimeScaleQuarters(minTimeScaleQuarters),
    .inductorDeratingSelect(inductorDeratingSelect), .deratingPercent(deratingPercent),
    .slopeCompSelect(slopeCompSelect), .slopeRatioEighths(slopeRatioEighths));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk({what, " valid"}, 8'h01, {7'h00, regRdValid});
    chk(what, exp, regRdData);
  endtask : rd

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    rd(8'hD5, 8'h3F, "threshold reg");
    rd(8'hD6, 8'h15, "timing reg");
    rd(8'hD7, 8'h28, "slope reg");
    rd(8'hD4, 8'h00, "unmapped reg");
    chk("half volts", 8'h6E, {1'b0, ovpLevelHalfVolts});
    chk("const dt", 8'h00, {7'h00, constDeadtimeEnable});
    chk("dt scaling", 8'h01, {7'h00, deadtimeScalingEnable});
    chk("dead ns", 8'h14, {2'b00, minDeadtimeNs});
    chk("min time", 8'h04, {5'h00, minTimeScaleQuarters});
    chk("derating", 8'h1E, {2'b00, deratingPercent});
    chk("slope", 8'h0C, {2'b00, slopeRatioEighths});
  endtask : test_reset_values

  // Boundary codes of both threshold ranges
  task automatic test_ovp();
    logic [5:0] codes [7] = '{6'h00, 6'h07, 6'h08, 6'h18, 6'h19, 6'h3E, 6'h3F};
    logic [7:0] e;
    foreach (codes[i]) begin
      wr(8'hD5, {2'b11, codes[i]});
      chk("level raw", {2'b00, codes[i]}, {2'b00, secondOvervoltageLevel});
      rd(8'hD5, {2'b00, codes[i]}, "threshold rb");
      e = (codes[i] <= 6'h18) ? 8'(codes[i]) + 8'h08 : 8'({codes[i], 1'b0}) - 8'h10;
      chk("half volts", e, {1'b0, ovpLevelHalfVolts});
    end
  endtask : test_ovp

  task automatic test_timing();
    logic [7:0] dtNs [4] = '{8'h0A, 8'h14, 8'h28, 8'h3C};
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      d = {2'(c), c[1], c[0], 2'(c), 2'(c)};
      wr(8'hD6, d);
      chk("sync raw", 8'(c), {6'h00, syncPinMode});
      chk("min dt sel", 8'(c), {6'h00, gateMinDeadtimeSelect});
      chk("min time sel", 8'(c), {6'h00, refreshMinTimeScale});
      rd(8'hD6, d, "timing rb");
      chk("sync drives", 8'(c[1]), {7'h00, syncDrivesPin});
      chk("sync fall", 8'(c[0]), {7'h00, syncFallingEdge});
      chk("const dt", 8'(c[1]), {7'h00, constDeadtimeEnable});
      chk("dt scaling", 8'(c[0]), {7'h00, deadtimeScalingEnable});
      chk("dead ns", dtNs[c], {2'b00, minDeadtimeNs});
      chk("min time", 8'(c + 3), {5'h00, minTimeScaleQuarters});
    end
  endtask : test_timing

  task automatic test_slope();
    logic [7:0] pct [4] = '{8'h00, 8'h14, 8'h1E, 8'h28};
    logic [7:0] e;
    for (int s = 0; s < 16; s++) begin
      wr(8'hD7, {2'b11, 2'(s), 4'(s)});
      chk("derate sel", 8'(s % 4), {6'h00, inductorDeratingSelect});
      chk("slope sel", 8'(s), {4'h0, slopeCompSelect});
      rd(8'hD7, {2'b00, 2'(s), 4'(s)}, "slope rb");
      e = (s < 8) ? 8'(s + 1) : 8'(4 * s - 20);
      chk("slope", e, {2'b00, slopeRatioEighths});
      chk("derating", pct[s % 4], {2'b00, deratingPercent});
    end
  endtask : test_slope

  // Frozen clock enable must drop the write
  task automatic test_freeze();
    @(posedge clk);
    clkEn <= 1'b0;
    wr(8'hD5, 8'h01);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(8'hD5, 8'h3F, "frozen write");
    chk("frozen level", 8'h3F, {2'b00, secondOvervoltageLevel});
    chk("frozen half volts", 8'h6E, {1'b0, ovpLevelHalfVolts});
  endtask : test_freeze

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset_values();
    test_ovp();
    test_timing();
    test_slope();
    test_freeze();
    // Leave a non-reset threshold so the second reset check means something
    wr(8'hD5, 8'h05);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset_values();
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
